// file: shared/terpx_pkg.sv
// constants and types for the encoder / retriggerable pulse timer extension
// assumes a single core clock; all users reference names as terpx_pkg::name
package terpx_pkg;

	// slave mode codes, top bit kept apart from the lower three
	localparam logic [3:0] SLV_ENC_T2   = 4'h1;
	localparam logic [3:0] SLV_ENC_T1   = 4'h2;
	localparam logic [3:0] SLV_ENC_BOTH = 4'h3;
	localparam logic [3:0] SLV_RST_TRIG = 4'h8;

	// output compare modes
	localparam logic [3:0] OCM_FROZEN   = 4'h0;
	localparam logic [3:0] OCM_FORCE_LO = 4'h4;
	localparam logic [3:0] OCM_FORCE_HI = 4'h5;
	localparam logic [3:0] OCM_PWM1     = 4'h6;
	localparam logic [3:0] OCM_PWM2     = 4'h7;
	localparam logic [3:0] OCM_RETRIG1  = 4'h8;
	localparam logic [3:0] OCM_RETRIG2  = 4'h9;

	// trigger source selection
	localparam logic [1:0] TRG_FP1  = 2'h0;
	localparam logic [1:0] TRG_FP2  = 2'h1;
	localparam logic [1:0] TRG_EDGE = 2'h2;

	// widths and defaults
	localparam int PSC_W        = 16;
	localparam int REP_W        = 8;
	localparam int CNT_W_DEF    = 32;
	localparam int FILT_LEN_DEF = 2;

	// values after reset
	localparam logic RST_REF  = 1'b0;
	localparam logic RST_FLAG = 1'b0;

	typedef enum logic [1:0] {
		PST_IDLE   = 2'b01,
		PST_ACTIVE = 2'b10
	} terpx_pulse_t;

endpackage

// file: verilog/terpx_infilt.sv
// digital input filter: output follows input after LEN equal samples
// assumes din is already synchronised to clk
`timescale 1ns/1ps
module terpx_infilt #(
	parameter int LEN = 2
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// level in and filtered level out
	input  wire logic din,
	output logic      dout
);
	localparam int CW = $clog2(LEN + 1);

	if (LEN < 1) begin : g_bad_len
		$error("filter length must be at least one");
	end

	logic [CW-1:0] run_q;

	// a glitch shorter than LEN samples never reaches dout
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			run_q <= '0;
			dout  <= 1'b0;
		end else if (din == dout) begin
			run_q <= '0;
		end else if (run_q == CW'(LEN - 1)) begin
			run_q <= '0;
			dout  <= din;
		end else begin
			run_q <= run_q + CW'(1);
		end
	end

endmodule

// file: verilog/terpx_core.sv
// timer counter with quadrature encoder, retriggerable single pulse,
// update flag mirror and three-pin xor input for channel 1
// assumes config ports are on CORE_CLK; channel pins are asynchronous
//
// Summary of operation
// - retriggerable pulse starts on the clock edge that ends the trigger cycle, no compare delay
// - a trigger during a pulse restarts the counter, lengthening the pulse
// - mode fields arrive as a separate top bit plus three low bits
// - slave codes 001, 010, 011 select encoder on input two, one, both
// - encoder counts each valid filtered edge, only while running
// - direction updates on every edge of either encoder input
// - encoder count wraps between zero and auto reload both ways
// - prescaler, repetition, capture, compare and trigger out still work
// - input one only: direction from input two level, input two edges not counted
// - input two only: direction from input one level, input one edges not counted
// - both inputs: every edge counts with its single-input direction
// - mirror enable copies update flag into counter read bit 31
// - mirror bit asserts in the same cycle as the update flag
// - true counter top bit stays writable but reads as the mirror
// - xor select feeds channel 1 filter with xor of three pins
// - xor signal serves trigger selection and capture of channel 1
// - reset+trigger: trigger edge reloads counter, updates and starts
`timescale 1ns/1ps
module terpx_core #(
	parameter int CNT_W    = terpx_pkg::CNT_W_DEF,
	parameter int FILT_LEN = terpx_pkg::FILT_LEN_DEF
) (
	// clock and reset
	input  wire logic        CORE_CLK,
	input  wire logic        RST_N,
	// channel pins
	input  wire logic        CH1_PIN,
	input  wire logic        CH2_PIN,
	input  wire logic        CH3_PIN,
	// mode configuration
	input  wire logic        SLAVE_MODE_SELECT_HI,
	input  wire logic [2:0]  SLAVE_MODE_SELECT_LO,
	input  wire logic        OUTPUT_COMPARE_MODE_HI,
	input  wire logic [2:0]  OUTPUT_COMPARE_MODE_LO,
	input  wire logic [1:0]  TRIGGER_SOURCE,
	input  wire logic        CH1_POLARITY,
	input  wire logic        CH2_POLARITY,
	input  wire logic        XOR_INPUT_SELECT,
	input  wire logic        FLAG_MIRROR_ENABLE,
	input  wire logic        SINGLE_PULSE,
	input  wire logic        DOWN_COUNT,
	input  wire logic        CAPTURE_ENABLE,
	// time base values
	input  wire logic [31:0] AUTO_RELOAD,
	input  wire logic [31:0] COMPARE_VALUE,
	input  wire logic [15:0] PRESCALER,
	input  wire logic [7:0]  REPETITION,
	// software strobes
	input  wire logic        COUNT_RUN_SET,
	input  wire logic        COUNT_RUN_CLR,
	input  wire logic        CNT_WRITE,
	input  wire logic [31:0] CNT_WDATA,
	input  wire logic        UPDATE_FLAG_CLR,
	input  wire logic        CAPTURE_FLAG_CLR,
	// status and outputs
	output logic [31:0]      COUNT_VALUE,
	output logic             UPDATE_FLAG,
	output logic             COUNT_DIR,
	output logic             COUNT_RUN,
	output logic             CH1_REF,
	output logic             TRIGGER_OUT,
	output logic [31:0]      CAPTURE_VALUE,
	output logic             CAPTURE_FLAG
);
	if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
		$error("counter width must lie in 2..32");
	end

	logic [2:0]                 sync_a_q;
	logic [2:0]                 sync_b_q;
	logic                       ch1_src;
	logic                       filt1;
	logic                       filt2;
	logic                       filt1_q;
	logic                       fp1;
	logic                       fp2;
	logic                       fp1_q;
	logic                       fp2_q;
	logic [3:0]                 smode;
	logic [3:0]                 ocm;
	logic                       enc_mode;
	logic                       e1;
	logic                       e2;
	logic                       enc_pulse;
	logic                       enc_dir_q;
	logic                       enc_dir_d;
	logic                       trig_edge;
	logic                       slv_trig;
	logic                       clk_src;
	logic                       tick;
	logic                       down;
	logic [CNT_W-1:0]           reload;
	logic [CNT_W-1:0]           ccr;
	logic [CNT_W-1:0]           cnt_q;
	logic [CNT_W-1:0]           cnt_d;
	logic [terpx_pkg::PSC_W-1:0] psc_q;
	logic [terpx_pkg::PSC_W-1:0] psc_d;
	logic [terpx_pkg::REP_W-1:0] rep_q;
	logic [terpx_pkg::REP_W-1:0] rep_d;
	logic                       wrap;
	logic                       uev_wrap;
	logic                       uev;
	logic                       uflag_d;
	logic                       run_d;
	logic                       ref_d;
	logic [31:0]                cv_d;
	terpx_pkg::terpx_pulse_t    pst_q;
	terpx_pkg::terpx_pulse_t    pst_d;

	// two-stage synchronisers for the three pins
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			sync_a_q <= 3'h0;
			sync_b_q <= 3'h0;
		end else begin
			sync_a_q <= {CH3_PIN, CH2_PIN, CH1_PIN};
			sync_b_q <= sync_a_q;
		end
	end

	assign ch1_src = XOR_INPUT_SELECT ? ^sync_b_q : sync_b_q[0];

	terpx_infilt #(.LEN(FILT_LEN)) u_filt1 (
		.clk   (CORE_CLK),
		.rst_n (RST_N),
		.din   (ch1_src),
		.dout  (filt1)
	);

	terpx_infilt #(.LEN(FILT_LEN)) u_filt2 (
		.clk   (CORE_CLK),
		.rst_n (RST_N),
		.din   (sync_b_q[1]),
		.dout  (filt2)
	);

	assign fp1   = filt1 ^ CH1_POLARITY;
	assign fp2   = filt2 ^ CH2_POLARITY;
	assign smode = {SLAVE_MODE_SELECT_HI, SLAVE_MODE_SELECT_LO};
	assign ocm   = {OUTPUT_COMPARE_MODE_HI, OUTPUT_COMPARE_MODE_LO};
	assign reload = AUTO_RELOAD[CNT_W-1:0];
	assign ccr   = COMPARE_VALUE[CNT_W-1:0];

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			fp1_q   <= 1'b0;
			fp2_q   <= 1'b0;
			filt1_q <= 1'b0;
		end else begin
			fp1_q   <= fp1;
			fp2_q   <= fp2;
			filt1_q <= filt1;
		end
	end

	// encoder decode; assumes the two inputs never move in the same cycle
	assign enc_mode = (smode == terpx_pkg::SLV_ENC_T2) || (smode == terpx_pkg::SLV_ENC_T1)
		|| (smode == terpx_pkg::SLV_ENC_BOTH);
	assign e1 = fp1 ^ fp1_q;
	assign e2 = fp2 ^ fp2_q;
	assign enc_pulse = ((smode == terpx_pkg::SLV_ENC_T1) && e1)
		|| ((smode == terpx_pkg::SLV_ENC_T2) && e2)
		|| ((smode == terpx_pkg::SLV_ENC_BOTH) && (e1 || e2));

	always_comb begin
		enc_dir_d = enc_dir_q;
		if (enc_mode && e1) begin
			enc_dir_d = ~(fp1 ^ fp2);
		end else if (enc_mode && e2) begin
			enc_dir_d = fp1 ^ fp2;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			enc_dir_q <= 1'b0;
		end else begin
			enc_dir_q <= enc_dir_d;
		end
	end

	// trigger selection, including the raw edge detector on channel 1
	always_comb begin
		case (TRIGGER_SOURCE)
			terpx_pkg::TRG_FP1:  trig_edge = fp1 & ~fp1_q;
			terpx_pkg::TRG_FP2:  trig_edge = fp2 & ~fp2_q;
			terpx_pkg::TRG_EDGE: trig_edge = filt1 ^ filt1_q;
			default:             trig_edge = 1'b0;
		endcase
	end

	assign slv_trig = (smode == terpx_pkg::SLV_RST_TRIG) && trig_edge;
	assign clk_src  = enc_mode ? enc_pulse : 1'b1;
	assign down     = enc_mode ? enc_dir_d : DOWN_COUNT;
	assign tick     = COUNT_RUN && clk_src && (psc_q == PRESCALER);

	// time base: trigger reload beats a software write beats counting
	always_comb begin
		cnt_d = cnt_q;
		psc_d = psc_q;
		wrap  = 1'b0;
		if (slv_trig) begin
			cnt_d = down ? reload : '0;
			psc_d = '0;
		end else if (CNT_WRITE) begin
			cnt_d = CNT_WDATA[CNT_W-1:0];
		end else if (COUNT_RUN && clk_src) begin
			if (psc_q == PRESCALER) begin
				psc_d = '0;
				if (down) begin
					if (cnt_q == '0) begin
						cnt_d = reload;
						wrap  = 1'b1;
					end else begin
						cnt_d = cnt_q - CNT_W'(1);
					end
				end else if (cnt_q >= reload) begin
					cnt_d = '0;
					wrap  = 1'b1;
				end else begin
					cnt_d = cnt_q + CNT_W'(1);
				end
			end else begin
				psc_d = psc_q + terpx_pkg::PSC_W'(1);
			end
		end
	end

	// repetition counter thins out wrap-driven updates
	always_comb begin
		rep_d    = rep_q;
		uev_wrap = 1'b0;
		if (slv_trig) begin
			rep_d = REPETITION;
		end else if (wrap) begin
			if (rep_q == '0) begin
				uev_wrap = 1'b1;
				rep_d    = REPETITION;
			end else begin
				rep_d = rep_q - terpx_pkg::REP_W'(1);
			end
		end
	end

	assign uev   = uev_wrap | slv_trig;
	assign uflag_d = uev | (UPDATE_FLAG & ~UPDATE_FLAG_CLR);

	always_comb begin
		run_d = COUNT_RUN;
		if (slv_trig) begin
			run_d = 1'b1;
		end else if (COUNT_RUN_SET) begin
			run_d = 1'b1;
		end else if (COUNT_RUN_CLR) begin
			run_d = 1'b0;
		end else if (uev_wrap && SINGLE_PULSE) begin
			run_d = 1'b0;
		end
	end

	// pulse tracker: ends with the wrap update; compare setup left to software
	always_comb begin
		pst_d = pst_q;
		if (slv_trig) begin
			pst_d = terpx_pkg::PST_ACTIVE;
		end else if (uev_wrap) begin
			pst_d = terpx_pkg::PST_IDLE;
		end
	end

	// reference is computed from next state so it moves with the counter
	always_comb begin
		case (ocm)
			terpx_pkg::OCM_FROZEN:   ref_d = CH1_REF;
			terpx_pkg::OCM_FORCE_LO: ref_d = 1'b0;
			terpx_pkg::OCM_FORCE_HI: ref_d = 1'b1;
			terpx_pkg::OCM_PWM1:     ref_d = down ? (cnt_d <= ccr) : (cnt_d < ccr);
			terpx_pkg::OCM_PWM2:     ref_d = down ? (cnt_d > ccr) : (cnt_d >= ccr);
			terpx_pkg::OCM_RETRIG1:  ref_d = pst_d != terpx_pkg::PST_ACTIVE;
			terpx_pkg::OCM_RETRIG2:  ref_d = pst_d == terpx_pkg::PST_ACTIVE;
			default:                 ref_d = CH1_REF;
		endcase
	end

	// read view: mirror shares the edge with the flag itself
	always_comb begin
		cv_d = 32'(cnt_d);
		if (FLAG_MIRROR_ENABLE) begin
			cv_d[31] = uflag_d;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			cnt_q       <= '0;
			psc_q       <= '0;
			rep_q       <= '0;
			pst_q       <= terpx_pkg::PST_IDLE;
			COUNT_RUN   <= 1'b0;
			UPDATE_FLAG <= terpx_pkg::RST_FLAG;
			COUNT_VALUE <= 32'h0;
			COUNT_DIR   <= 1'b0;
			CH1_REF     <= terpx_pkg::RST_REF;
			TRIGGER_OUT <= 1'b0;
		end else begin
			cnt_q       <= cnt_d;
			psc_q       <= psc_d;
			rep_q       <= rep_d;
			pst_q       <= pst_d;
			COUNT_RUN   <= run_d;
			UPDATE_FLAG <= uflag_d;
			COUNT_VALUE <= cv_d;
			COUNT_DIR   <= down;
			CH1_REF     <= ref_d;
			TRIGGER_OUT <= uev;
		end
	end

	// input capture on channel 1; a new capture beats a same-cycle clear
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			CAPTURE_VALUE <= 32'h0;
			CAPTURE_FLAG  <= terpx_pkg::RST_FLAG;
		end else if (CAPTURE_ENABLE && fp1 && !fp1_q) begin
			CAPTURE_VALUE <= 32'(cnt_q);
			CAPTURE_FLAG  <= 1'b1;
		end else if (CAPTURE_FLAG_CLR) begin
			CAPTURE_FLAG  <= 1'b0;
		end
	end

	chk_retrig_two_start: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		(slv_trig && ocm == terpx_pkg::OCM_RETRIG2) |=> CH1_REF)
		else $error("mode 2 pulse did not start on trigger");
	chk_retrig_one_start: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		(slv_trig && ocm == terpx_pkg::OCM_RETRIG1) |=> !CH1_REF)
		else $error("mode 1 pulse polarity wrong");
	chk_pulse_extend: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		(slv_trig && pst_q == terpx_pkg::PST_ACTIVE)
		|=> (pst_q == terpx_pkg::PST_ACTIVE) && (psc_q == '0))
		else $error("retrigger did not extend pulse");
	chk_trig_reload: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		slv_trig |=> UPDATE_FLAG && COUNT_RUN && TRIGGER_OUT
		&& (cnt_q == ($past(down) ? $past(reload) : '0)))
		else $error("trigger did not reload and start");
	chk_enc_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		(enc_mode && !COUNT_RUN && !CNT_WRITE && !slv_trig) |=> $stable(cnt_q))
		else $error("encoder counted while stopped");
	chk_dir_track: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		(enc_mode && e1) |=> COUNT_DIR == ~($past(fp1) ^ $past(fp2)))
		else $error("direction not updated on input one edge");
	chk_enc_wrap: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		(enc_mode && tick && down && cnt_q == '0 && !slv_trig && !CNT_WRITE)
		|=> cnt_q == $past(reload))
		else $error("encoder did not wrap down to auto reload");
	chk_t1_ignore_t2: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		(smode == terpx_pkg::SLV_ENC_T1 && e2 && !e1 && !CNT_WRITE) |=> $stable(cnt_q))
		else $error("input two edge counted in input one mode");
	chk_t2_ignore_t1: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		(smode == terpx_pkg::SLV_ENC_T2 && e1 && !e2 && !CNT_WRITE) |=> $stable(cnt_q))
		else $error("input one edge counted in input two mode");
	chk_both_counts: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		(smode == terpx_pkg::SLV_ENC_BOTH && COUNT_RUN && (e1 || e2) && PRESCALER == '0
		&& psc_q == '0 && reload != '0 && !CNT_WRITE) |=> cnt_q != $past(cnt_q))
		else $error("edge missed in both-input mode");
	chk_mirror_same: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		$past(FLAG_MIRROR_ENABLE) |-> COUNT_VALUE[31] == UPDATE_FLAG)
		else $error("mirror bit differs from update flag");

endmodule

// file: bench/terpx_pin_src.sv
// partner model: quadrature encoder and trigger source on the three channel pins
// assumes one bench process calls move() at a time, on the core clock
`timescale 1ns/1ps
module terpx_pin_src (
	// clock
	input  wire logic clk,
	// pin levels
	output logic      pin1,
	output logic      pin2,
	output logic      pin3
);
	initial begin
		pin1 = 1'b0;
		pin2 = 1'b0;
		pin3 = 1'b0;
	end

	// one pin moves at a time, as a real encoder does; hold covers sync and filter delay
	task automatic move(input int w, input int hold);
		@(posedge clk);
		#1;
		case (w)
			1: pin1 = ~pin1;
			2: pin2 = ~pin2;
			default: pin3 = ~pin3;
		endcase
		repeat (hold) @(posedge clk);
		#1;
	endtask
endmodule

// file: bench/timer_encoder_retrig_pulse_xor_test.sv
// self-checking bench for the encoder / retriggerable pulse timer extension
// assumes terpx_core, terpx_infilt and terpx_pkg are compiled first
`timescale 1ns/1ps
module timer_encoder_retrig_pulse_xor_test;
	logic        clk, rst_n, sm_hi, oc_hi, pol1, pol2, xsel, mir, spulse, down, cap_en;
	logic [2:0]  sm_lo, oc_lo;
	logic [1:0]  trg_src;
	logic [31:0] reload, ccr, wdata, cnt_val, cap_val;
	logic [15:0] psc;
	logic [7:0]  rep;
	logic        run_set, run_clr, cwr, fclr, cclr;
	logic        uflag, dir, run, ref_o, trg_out, cap_flag, mflag;
	wire         pin1, pin2, pin3;
	int          num_errors, n_compared, mcnt, w, up, act, len;
	int          cycles = 0;

	terpx_pin_src src (.clk(clk), .pin1(pin1), .pin2(pin2), .pin3(pin3));

	terpx_core #(.CNT_W(32), .FILT_LEN(2)) dut (
		.CORE_CLK(clk), .RST_N(rst_n), .CH1_PIN(pin1), .CH2_PIN(pin2), .CH3_PIN(pin3),
		.SLAVE_MODE_SELECT_HI(sm_hi), .SLAVE_MODE_SELECT_LO(sm_lo),
		.OUTPUT_COMPARE_MODE_HI(oc_hi), .OUTPUT_COMPARE_MODE_LO(oc_lo),
		.TRIGGER_SOURCE(trg_src), .CH1_POLARITY(pol1), .CH2_POLARITY(pol2),
		.XOR_INPUT_SELECT(xsel), .FLAG_MIRROR_ENABLE(mir), .SINGLE_PULSE(spulse),
		.DOWN_COUNT(down), .CAPTURE_ENABLE(cap_en), .AUTO_RELOAD(reload),
		.COMPARE_VALUE(ccr), .PRESCALER(psc), .REPETITION(rep),
		.COUNT_RUN_SET(run_set), .COUNT_RUN_CLR(run_clr), .CNT_WRITE(cwr),
		.CNT_WDATA(wdata), .UPDATE_FLAG_CLR(fclr), .CAPTURE_FLAG_CLR(cclr),
		.COUNT_VALUE(cnt_val), .UPDATE_FLAG(uflag), .COUNT_DIR(dir), .COUNT_RUN(run),
		.CH1_REF(ref_o), .TRIGGER_OUT(trg_out), .CAPTURE_VALUE(cap_val),
		.CAPTURE_FLAG(cap_flag)
	);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// the whole run needs about 1600 cycles; a hang is stopped at the 5000-cycle budget
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			num_errors++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic drive_strobe(input int k, input logic v);
		case (k)
			0: run_set = v;
			1: run_clr = v;
			2: fclr = v;
			3: cclr = v;
			default: cwr = v;
		endcase
	endtask

	// one-cycle software strobe, dropped one edge later; only its own line moves
	task automatic strobe(input int k);
		drive_strobe(k, 1'b1);
		tick(1);
		drive_strobe(k, 1'b0);
	endtask

	initial begin
		void'($urandom(32'hdb86));
		{sm_hi, sm_lo, oc_hi, oc_lo, trg_src, pol1, pol2, xsel} = '0;
		{spulse, down, cap_en, run_set, run_clr, cwr, fclr, cclr, rst_n} = '0;
		{reload, ccr, wdata, psc, rep} = '0;
		mir = 1'b1;
		num_errors = 0;
		n_compared = 0;
		tick(6);
		rst_n = 1'b1;
		tick(4);
		// encoder: every encoder slave code, random polarity and edges, run cleared near the end
		for (int m = 1; m <= 3; m++) begin
			{sm_hi, sm_lo} = m[3:0];
			pol1 = 1'($urandom_range(1));
			pol2 = 1'($urandom_range(1));
			reload = $urandom_range(9, 3);
			tick(10);
			wdata = '0;
			strobe(4);
			strobe(2);
			strobe(0);
			mcnt = 0;
			mflag = 1'b0;
			for (int i = 0; i < 40; i++) begin
				w = $urandom_range(2, 1);
				if (i == 32)
					strobe(1);
				src.move(w, 10);
				up = int'(src.pin1 ^ pol1 ^ src.pin2 ^ pol2 ^ (w == 2));
				if (i < 32 && ((m >> (2 - w)) & 1)) begin
					if (up) begin
						mflag = mflag | (mcnt >= reload);
						mcnt = (mcnt >= reload) ? 0 : mcnt + 1;
					end else begin
						mflag = mflag | (mcnt == 0);
						mcnt = (mcnt == 0) ? reload : mcnt - 1;
					end
				end
				chk("dir", dir, !up);
				chk("count", cnt_val, {mflag, 31'(mcnt)});
				chk("flag", uflag, mflag);
			end
		end
		// true top bit is writable but hidden while the mirror is on
		wdata = 32'h8000_0002;
		strobe(4);
		strobe(2);
		chk("mirror_on", cnt_val, 32'h0000_0002);
		mir = 1'b0;
		tick(2);
		chk("mirror_off", cnt_val, 32'h8000_0002);
		// xor of three pins into channel 1, seen by capture
		{sm_hi, sm_lo} = 4'h0;
		pol1 = 1'b0;
		cap_en = 1'b1;
		// counter stays stopped, so a capture must return the written value
		wdata = $urandom();
		strobe(4);
		strobe(3);
		src.move(3, 10);
		chk("cap_plain", cap_flag, 1'b0);
		xsel = 1'b1;
		tick(10);
		if (src.pin1 ^ src.pin2 ^ src.pin3)
			src.move(3, 10);
		strobe(3);
		src.move(3, 10);
		chk("cap_xor", cap_flag, 1'b1);
		chk("cap_val", cap_val, wdata);
		// retriggerable pulse, triggered through the xor signal
		strobe(1);
		{sm_hi, sm_lo} = 4'h8;
		spulse = 1'b1;
		ccr = '0;
		for (int k = 9; k >= 8; k--) begin
			{oc_hi, oc_lo} = k[3:0];
			act = (k == 9);
			// mode 1 pass triggers on any xor edge; the last rising edge still ends last
			trg_src = (k == 8) ? 2'h2 : 2'h0;
			reload = $urandom_range(20, 12);
			src.move(3, 40);
			strobe(2);
			fork
				begin
					src.move(3, 4);
					src.move(3, 5);
					src.move(3, 1);
				end
				begin
					len = 0;
					while (run !== 1'b1 && len < 30) begin
						tick(1);
						len++;
					end
					chk("start_cnt", cnt_val, 32'h0);
					chk("start_flag", uflag, 1'b1);
					chk("start_ref", ref_o, act);
					chk("start_trgo", trg_out, 1'b1);
					len = 0;
					while (run === 1'b1 && ref_o === act[0] && len < 200) begin
						tick(1);
						len++;
					end
					// second rising edge comes 11 cycles after the first
					chk("pulse_len", len, 12 + reload);
					chk("end_ref", ref_o, !act);
					chk("end_run", run, 1'b0);
				end
			join
		end
		wrap_up();
	end
endmodule
